// ===== flp_nvm_protect.sv
// Decided for this implementation: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
`include "flp_regs.svh"
// Contract
// - locked-region erase or program aborts, sets error
// - interrupt only when lock error enable set
// - eight regions of 32 pages, 128 bytes
// - eight regions of 32 pages, 64 bytes
// - set-lock and clear-lock commands per region
// - wipe pin clears every lock bit
// - security blocks debug and fast-port access
// - security set only by command, cleared only by wipe then full erase
// - security clears after wipe then full erase
// - two general bits, set/clear commands
// - general bit 0 enables undervoltage detector
// - wipe pin clears general bit 0
// - general bit 1 enables undervoltage reset
// - wipe pin clears general bit 1
// - eight factory calibration bits, read only
// - wipe pin leaves calibration bits alone
// - straps 0111 enter fast programming mode
// - fast port accepts all listed commands
// - all straps high 10 s restores boot
// - registers reached over the peripheral bus
module flp_nvm_protect #(
  parameter int NUM_REGIONS = 8,
  parameter int PAGES_PER_REGION = 32,
  parameter int PAGE_BYTES = 128,
  parameter logic [7:0] CALIB_VALUE = `FLP_CALIB_DEFAULT,
  parameter int RESTORE_CYCLES = `FLP_RESTORE_CYCLES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // pins
  input wire logic wipePin,
  input wire logic testStrapPin,
  input wire logic strapLineZero,
  input wire logic strapLineOne,
  input wire logic strapLineTwo,
  // debug emulator port access
  input wire logic dbgAccessReq,
  output logic dbgAccessGrant_ff,
  // fast program port commands
  input wire logic fppCmdValid,
  input wire logic [3:0] fppCmd,
  input wire logic [15:0] fppArg,
  output logic fppCmdDone_ff,
  output logic fppCmdRefused_ff,
  output logic fastProgMode_ff,
  // flash array handshake
  output logic pageProgStart_ff,
  output logic pageEraseStart_ff,
  output logic fullEraseStart_ff,
  output logic [15:0] flashPage_ff,
  input wire logic fullEraseDone,
  // system outputs
  output logic flashIrq_ff,
  output logic bodEnable_ff,
  output logic bodResetEnable_ff,
  output logic [7:0] calibBits_ff,
  output logic bootRestore_ff
);
  localparam int RIDX_W = (NUM_REGIONS > 1) ? $clog2(NUM_REGIONS) : 1;

  initial begin
    if (NUM_REGIONS != 8 || PAGES_PER_REGION != 32) begin
      $error("flp_nvm_protect: only 8 regions of 32 pages supported");
    end
    if (PAGE_BYTES != 128 && PAGE_BYTES != 64) begin
      $error("flp_nvm_protect: page size must be 64 or 128 bytes");
    end
  end

  // ==========================================================
  // ahb-lite address phase capture, zero wait states
  logic dpValid_ff;
  logic dpWrite_ff;
  logic [7:0] dpAddr_ff;
  logic apTake;
  assign apTake = hsel && htrans[1] && hready;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      dpValid_ff <= 1'b0;
      dpWrite_ff <= 1'b0;
      dpAddr_ff <= 8'h00;
    end else begin
      dpValid_ff <= apTake;
      dpWrite_ff <= apTake && hwrite;
      if (apTake) begin
        dpAddr_ff <= haddr;
      end
    end
  end

  logic wrMode;
  logic wrCmd;
  logic rdStatus;
  assign wrMode = dpWrite_ff && (dpAddr_ff == `FLP_OFS_MODE);
  assign wrCmd = dpWrite_ff && (dpAddr_ff == `FLP_OFS_CMD);
  assign rdStatus = apTake && !hwrite && (haddr == `FLP_OFS_STATUS);

  // ==========================================================
  // wipe pin synchroniser
  logic wipeA_ff;
  logic wipeB_ff;
  logic wipeC_ff;
  logic wipeLevel_ff;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wipeA_ff <= 1'b0;
      wipeB_ff <= 1'b0;
      wipeC_ff <= 1'b0;
      wipeLevel_ff <= 1'b0;
    end else begin
      wipeA_ff <= wipePin;
      wipeB_ff <= wipeA_ff;
      wipeC_ff <= wipeB_ff;
      if (wipeB_ff == wipeC_ff) begin
        wipeLevel_ff <= wipeC_ff;
      end
    end
  end

  // ==========================================================
  // strap decode
  logic fastProgEn;

  flp_strap_decode #(
    .RESTORE_CYCLES(RESTORE_CYCLES)
  ) u_strap (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .testStrapPin(testStrapPin),
    .strapLineZero(strapLineZero),
    .strapLineOne(strapLineOne),
    .strapLineTwo(strapLineTwo),
    .fastProgEn_ff(fastProgEn),
    .bootRestore_ff(bootRestore_ff)
  );

  // ==========================================================
  // command source selection, bus first, fast port when idle
  logic securityOn_ff;
  logic fppAllowed;
  logic fppTake;
  logic execValid;
  flp_pkg::flp_cmd_t execCmd;
  logic [15:0] execArg;
  assign fppAllowed = fastProgEn && !securityOn_ff;
  assign fppTake = fppCmdValid && fppAllowed && !wrCmd;
  assign execValid = wrCmd || fppTake;
  assign execCmd = wrCmd ? flp_pkg::flp_cmd_t'(hwdata[`FLP_CMD_CODE_LSB +: 4])
                         : flp_pkg::flp_cmd_t'(fppCmd);
  assign execArg = wrCmd ? hwdata[`FLP_CMD_ARG_LSB +: 16] : fppArg;

  logic [NUM_REGIONS-1:0] lockBits_ff;
  logic [RIDX_W-1:0] regionIdx;
  logic regionLocked;
  assign regionIdx = RIDX_W'(execArg / 16'(PAGES_PER_REGION));
  assign regionLocked = lockBits_ff[regionIdx];

  logic isPageOp;
  logic isFullErase;
  logic lockHit;
  assign isPageOp = execValid && (execCmd == flp_pkg::FLP_CMD_PAGE_PROG
                                  || execCmd == flp_pkg::FLP_CMD_PAGE_ERASE);
  assign isFullErase = execValid && (execCmd == flp_pkg::FLP_CMD_FULL_ERASE);
  assign lockHit = (isPageOp && regionLocked) || (isFullErase && (|lockBits_ff));

  // ==========================================================
  // lock bits, one per region
  genvar gr;
  generate
    for (gr = 0; gr < NUM_REGIONS; gr++) begin : g_lock
      always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
          lockBits_ff[gr] <= 1'b0;
        end else if (wipeLevel_ff) begin
          lockBits_ff[gr] <= 1'b0;
        end else if (execValid && regionIdx == RIDX_W'(gr)) begin
          if (execCmd == flp_pkg::FLP_CMD_SET_LOCK) begin
            lockBits_ff[gr] <= 1'b1;
          end else if (execCmd == flp_pkg::FLP_CMD_CLR_LOCK) begin
            lockBits_ff[gr] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // ==========================================================
  // flash array start pulses, aborted on lock hit
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pageProgStart_ff <= 1'b0;
      pageEraseStart_ff <= 1'b0;
      fullEraseStart_ff <= 1'b0;
      flashPage_ff <= 16'h0000;
    end else begin
      pageProgStart_ff <= isPageOp && !lockHit
                          && execCmd == flp_pkg::FLP_CMD_PAGE_PROG;
      pageEraseStart_ff <= isPageOp && !lockHit
                           && execCmd == flp_pkg::FLP_CMD_PAGE_ERASE;
      fullEraseStart_ff <= isFullErase && !lockHit;
      if (isPageOp) begin
        flashPage_ff <= execArg;
      end
    end
  end

  // ==========================================================
  // lock error flag, set wins over clear-on-read
  logic lockErr_ff;
  logic cmdDone_ff;
  logic lockErrEn_ff;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      lockErr_ff <= 1'b0;
      cmdDone_ff <= 1'b0;
    end else begin
      if (lockHit) begin
        lockErr_ff <= 1'b1;
      end else if (rdStatus) begin
        lockErr_ff <= 1'b0;
      end
      if (execValid) begin
        cmdDone_ff <= 1'b1;
      end else if (rdStatus) begin
        cmdDone_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      lockErrEn_ff <= 1'b0;
      flashIrq_ff <= 1'b0;
    end else begin
      if (wrMode) begin
        lockErrEn_ff <= hwdata[`FLP_MODE_LOCKERR_EN];
      end
      flashIrq_ff <= lockErr_ff && lockErrEn_ff;
    end
  end

  // ==========================================================
  // security bit and wipe arming
  logic wipeArmed_ff;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      securityOn_ff <= 1'b0;
      wipeArmed_ff <= 1'b0;
    end else begin
      if (wipeLevel_ff) begin
        wipeArmed_ff <= 1'b1;
      end else if (fullEraseDone) begin
        wipeArmed_ff <= 1'b0;
      end
      if (execValid && execCmd == flp_pkg::FLP_CMD_SET_SEC) begin
        securityOn_ff <= 1'b1;
      end else if (wipeArmed_ff && fullEraseDone) begin
        securityOn_ff <= 1'b0;
      end
    end
  end

  // ==========================================================
  // general-purpose bits and calibration
  logic [1:0] gpBits_ff;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      gpBits_ff <= 2'b00;
    end else if (wipeLevel_ff) begin
      gpBits_ff <= 2'b00;
    end else if (execValid && execCmd == flp_pkg::FLP_CMD_SET_GP) begin
      gpBits_ff[execArg[0]] <= 1'b1;
    end else if (execValid && execCmd == flp_pkg::FLP_CMD_CLR_GP) begin
      gpBits_ff[execArg[0]] <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      bodEnable_ff <= 1'b0;
      bodResetEnable_ff <= 1'b0;
      calibBits_ff <= 8'h00;
    end else begin
      bodEnable_ff <= gpBits_ff[0];
      bodResetEnable_ff <= gpBits_ff[1];
      calibBits_ff <= CALIB_VALUE;
    end
  end

  // ==========================================================
  // external access gating
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      dbgAccessGrant_ff <= 1'b0;
      fppCmdDone_ff <= 1'b0;
      fppCmdRefused_ff <= 1'b0;
      fastProgMode_ff <= 1'b0;
    end else begin
      dbgAccessGrant_ff <= dbgAccessReq && !securityOn_ff;
      fppCmdDone_ff <= fppTake;
      fppCmdRefused_ff <= fppCmdValid && !fppAllowed;
      fastProgMode_ff <= fastProgEn;
    end
  end

  // ==========================================================
  // read data, registered in the address phase
  logic [31:0] rdMux;

  always_comb begin
    rdMux = 32'h0000_0000;
    unique case (haddr)
      `FLP_OFS_MODE: rdMux[`FLP_MODE_LOCKERR_EN] = lockErrEn_ff;
      `FLP_OFS_STATUS: begin
        rdMux[`FLP_ST_DONE] = cmdDone_ff;
        rdMux[`FLP_ST_LOCKERR] = lockErr_ff;
        rdMux[`FLP_ST_SECURITY] = securityOn_ff;
        rdMux[`FLP_ST_FASTPROG] = fastProgEn;
        rdMux[`FLP_ST_WIPEARMED] = wipeArmed_ff;
      end
      `FLP_OFS_LOCKS: rdMux[NUM_REGIONS-1:0] = lockBits_ff;
      `FLP_OFS_NVBITS: begin
        rdMux[1:0] = gpBits_ff;
        rdMux[`FLP_NV_CALIB_LSB +: 8] = calibBits_ff;
      end
      default: rdMux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      if (apTake && !hwrite) begin
        hrdata <= rdMux;
      end
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end
endmodule : flp_nvm_protect

// ===== flp_regs.svh
`ifndef FLP_REGS_SVH
`define FLP_REGS_SVH
// ==========================================================
// register byte offsets
`define FLP_OFS_MODE 8'h00
`define FLP_OFS_CMD 8'h04
`define FLP_OFS_STATUS 8'h08
`define FLP_OFS_LOCKS 8'h0C
`define FLP_OFS_NVBITS 8'h10
// ==========================================================
// field positions
`define FLP_MODE_LOCKERR_EN 0
`define FLP_CMD_CODE_LSB 0
`define FLP_CMD_ARG_LSB 8
`define FLP_ST_DONE 0
`define FLP_ST_LOCKERR 2
`define FLP_ST_SECURITY 4
`define FLP_ST_FASTPROG 5
`define FLP_ST_WIPEARMED 6
`define FLP_NV_CALIB_LSB 8
// ==========================================================
// reset values and timing
`define FLP_CALIB_DEFAULT 8'h00
`define FLP_CLK_HZ 10000000
`define FLP_RESTORE_TIME_S 10
`define FLP_RESTORE_CYCLES (`FLP_RESTORE_TIME_S * `FLP_CLK_HZ)
`endif

// ===== flp_pkg.sv
package flp_pkg;
  typedef enum logic [3:0] {
    FLP_CMD_NONE = 4'h0,
    FLP_CMD_PAGE_PROG = 4'h1,
    FLP_CMD_PAGE_ERASE = 4'h2,
    FLP_CMD_FULL_ERASE = 4'h3,
    FLP_CMD_SET_LOCK = 4'h4,
    FLP_CMD_CLR_LOCK = 4'h5,
    FLP_CMD_SET_SEC = 4'h6,
    FLP_CMD_SET_GP = 4'h7,
    FLP_CMD_CLR_GP = 4'h8,
    FLP_CMD_READ = 4'h9
  } flp_cmd_t;
endpackage : flp_pkg

// ===== flp_strap_decode.sv
`timescale 1ns/1ps
`include "flp_regs.svh"
module flp_strap_decode #(
  parameter int RESTORE_CYCLES = `FLP_RESTORE_CYCLES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // strap pins
  input wire logic testStrapPin,
  input wire logic strapLineZero,
  input wire logic strapLineOne,
  input wire logic strapLineTwo,
  // decoded modes
  output logic fastProgEn_ff,
  output logic bootRestore_ff
);
  initial begin
    if (RESTORE_CYCLES < 2) begin
      $error("flp_strap_decode: RESTORE_CYCLES too small");
    end
  end

  // ==========================================================
  // three-stage synchronisers, level taken when stages 2 and 3 agree
  logic [3:0] pinRaw;
  logic [3:0] syncA_ff;
  logic [3:0] syncB_ff;
  logic [3:0] syncC_ff;
  logic [3:0] strapLevel_ff;
  assign pinRaw = {strapLineTwo, strapLineOne, strapLineZero, testStrapPin};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
          syncA_ff[gi] <= 1'b0;
          syncB_ff[gi] <= 1'b0;
          syncC_ff[gi] <= 1'b0;
          strapLevel_ff[gi] <= 1'b0;
        end else begin
          syncA_ff[gi] <= pinRaw[gi];
          syncB_ff[gi] <= syncA_ff[gi];
          syncC_ff[gi] <= syncB_ff[gi];
          if (syncB_ff[gi] == syncC_ff[gi]) begin
            strapLevel_ff[gi] <= syncC_ff[gi];
          end
        end
      end
    end
  endgenerate

  // ==========================================================
  // fast programming entry
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      fastProgEn_ff <= 1'b0;
    end else begin
      fastProgEn_ff <= (strapLevel_ff == 4'b0111);
    end
  end

  // ==========================================================
  // boot recovery after all straps high for the hold time
  logic [31:0] holdCnt_ff;
  logic allHigh;
  assign allHigh = (strapLevel_ff == 4'b1111);

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      holdCnt_ff <= 32'h0000_0000;
      bootRestore_ff <= 1'b0;
    end else begin
      bootRestore_ff <= 1'b0;
      if (!allHigh) begin
        holdCnt_ff <= 32'h0000_0000;
      end else if (holdCnt_ff < 32'(RESTORE_CYCLES)) begin
        holdCnt_ff <= holdCnt_ff + 32'h0000_0001;
        bootRestore_ff <= (holdCnt_ff == 32'(RESTORE_CYCLES - 1));
      end
    end
  end
endmodule : flp_strap_decode

// ===== flp_nvm_protect_monitor.sv
`timescale 1ns/1ps
// ==========================================================
// port checker
module flp_nvm_protect_monitor #(
  parameter logic [7:0] CALIB_VALUE = 8'h00
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // pins
  input wire logic wipePin,
  input wire logic testStrapPin,
  input wire logic strapLineZero,
  input wire logic strapLineOne,
  input wire logic strapLineTwo,
  // ports
  input wire logic dbgAccessReq,
  input wire logic dbgAccessGrant_ff,
  input wire logic fppCmdValid,
  input wire logic fppCmdDone_ff,
  input wire logic fppCmdRefused_ff,
  input wire logic fastProgMode_ff,
  // outputs
  input wire logic pageProgStart_ff,
  input wire logic pageEraseStart_ff,
  input wire logic fullEraseStart_ff,
  input wire logic bodEnable_ff,
  input wire logic bodResetEnable_ff,
  input wire logic [7:0] calibBits_ff,
  input wire logic bootRestore_ff
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus answer not ready okay");
  rdata_hold_a: assert property (!$past(hsel && htrans[1] && !hwrite)
    |-> $stable(hrdata))
    else $error("read data moved without read");
  dbg_cause_a: assert property (dbgAccessGrant_ff |-> $past(dbgAccessReq))
    else $error("debug grant without request");
  fpp_done_a: assert property (fppCmdDone_ff |-> $past(fppCmdValid)
    && fastProgMode_ff && !fppCmdRefused_ff)
    else $error("fast command done without cause");
  fpp_ref_a: assert property (fppCmdRefused_ff |-> $past(fppCmdValid))
    else $error("refusal without command");
  start_excl_a: assert property (pageProgStart_ff
    |-> !pageEraseStart_ff && !fullEraseStart_ff)
    else $error("two flash starts at once");
  calib_fixed_a: assert property ($past(arst_n)
    |-> calibBits_ff == CALIB_VALUE)
    else $error("calibration bits changed");
  wipe_gp_a: assert property (wipePin [*8]
    |-> !bodEnable_ff && !bodResetEnable_ff)
    else $error("general bits kept during wipe");
  fast_on_a: assert property (
    (testStrapPin && strapLineZero && strapLineOne && !strapLineTwo) [*8] |-> fastProgMode_ff)
    else $error("fast mode not entered");
  fast_off_a: assert property (!testStrapPin [*8] |-> !fastProgMode_ff)
    else $error("fast mode without strap");
  boot_cause_a: assert property (bootRestore_ff
    |-> $past(strapLineTwo, 8) && $past(testStrapPin, 8))
    else $error("boot restore without straps");
endmodule : flp_nvm_protect_monitor

bind flp_nvm_protect flp_nvm_protect_monitor #(.CALIB_VALUE(CALIB_VALUE)) u_mon (
  .clk_sys(clk_sys), .arst_n(arst_n), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .wipePin(wipePin),
  .testStrapPin(testStrapPin), .strapLineZero(strapLineZero), .strapLineOne(strapLineOne),
  .strapLineTwo(strapLineTwo), .dbgAccessReq(dbgAccessReq), .dbgAccessGrant_ff(dbgAccessGrant_ff),
  .fppCmdValid(fppCmdValid), .fppCmdDone_ff(fppCmdDone_ff), .fppCmdRefused_ff(fppCmdRefused_ff),
  .fastProgMode_ff(fastProgMode_ff), .pageProgStart_ff(pageProgStart_ff),
  .pageEraseStart_ff(pageEraseStart_ff), .fullEraseStart_ff(fullEraseStart_ff),
  .bodEnable_ff(bodEnable_ff), .bodResetEnable_ff(bodResetEnable_ff),
  .calibBits_ff(calibBits_ff), .bootRestore_ff(bootRestore_ff));

// ===== flp_flash_model.sv
`timescale 1ns/1ps
// ==========================================================
// flash array erase responder
module flp_flash_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // erase handshake
  input wire logic slow,
  input wire logic eraseStart,
  output logic eraseDone
);
  int cnt;
  // one-cycle done once the erase delay runs out
  assign eraseDone = (cnt == 1);
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 0;
    end else if (eraseStart) begin
      cnt <= slow ? 40 : 4;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
    end
  end
endmodule : flp_flash_model

// ===== flp_nvm_protect_tb.sv
`timescale 1ns/1ps
module flp_nvm_protect_tb;
  localparam logic [7:0] CAL = 8'h5A; // arbitrary calibration value
  localparam int RST_CYC = 50;
  // shortened wipe hold; the device does not time it
  localparam int WIPE_CYC = 2000;
  logic clk_sys = 1'b0, arst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, slow = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'b00;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000, hrdata, rnd = 32'h0000_2798;
  logic hreadyout, hresp, wipePin = 1'b0, dbgAccessReq = 1'b0, dbgAccessGrant_ff;
  logic [3:0] straps = 4'h0, fppCmd = 4'h0;
  logic fppCmdValid = 1'b0, fppCmdDone_ff, fppCmdRefused_ff, fastProgMode_ff, fullEraseDone;
  logic [15:0] fppArg = 16'h0000, flashPage_ff, lastPage = 16'h0000;
  logic pageProgStart_ff, pageEraseStart_ff, fullEraseStart_ff, flashIrq_ff;
  logic bodEnable_ff, bodResetEnable_ff, bootRestore_ff;
  logic [7:0] calibBits_ff;
  logic [3:0] codes [9] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h7, 4'h8, 4'h9, 4'h6};
  int n_mismatch = 0, checks_done = 0, cyc = 0, nProg = 0, nFull = 0, nDone = 0, nRef = 0;
  int nBoot = 0, lockM = 0, gpM = 0, secM = 0, errM = 0, fastM = 0, eS = 0, eF = 0, pg;

  always #50 clk_sys = ~clk_sys;

  flp_nvm_protect #(.CALIB_VALUE(CAL), .RESTORE_CYCLES(RST_CYC)) uut (
    .clk_sys(clk_sys), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .wipePin(wipePin), .testStrapPin(straps[3]),
    .strapLineZero(straps[2]), .strapLineOne(straps[1]), .strapLineTwo(straps[0]),
    .dbgAccessReq(dbgAccessReq), .dbgAccessGrant_ff(dbgAccessGrant_ff),
    .fppCmdValid(fppCmdValid), .fppCmd(fppCmd), .fppArg(fppArg), .fppCmdDone_ff(fppCmdDone_ff),
    .fppCmdRefused_ff(fppCmdRefused_ff), .fastProgMode_ff(fastProgMode_ff),
    .pageProgStart_ff(pageProgStart_ff), .pageEraseStart_ff(pageEraseStart_ff),
    .fullEraseStart_ff(fullEraseStart_ff), .flashPage_ff(flashPage_ff),
    .fullEraseDone(fullEraseDone), .flashIrq_ff(flashIrq_ff), .bodEnable_ff(bodEnable_ff),
    .bodResetEnable_ff(bodResetEnable_ff), .calibBits_ff(calibBits_ff),
    .bootRestore_ff(bootRestore_ff));

  flp_flash_model u_flash (.clk_sys(clk_sys), .arst_n(arst_n), .slow(slow),
    .eraseStart(fullEraseStart_ff), .eraseDone(fullEraseDone));

  always @(posedge clk_sys) begin
    nProg <= nProg + pageProgStart_ff + pageEraseStart_ff;
    nFull <= nFull + fullEraseStart_ff;
    nDone <= nDone + fppCmdDone_ff;
    nRef <= nRef + fppCmdRefused_ff;
    nBoot <= nBoot + bootRestore_ff;
    if (pageProgStart_ff || pageEraseStart_ff) lastPage <= flashPage_ff;
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : xfer

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    xfer(a, 1'b0, 32'h0000_0000, r);
    chk(r, exp);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(a, 1'b1, d, r);
  endtask : wr

  task automatic rdSt;
    logic [31:0] r;
    xfer(8'h08, 1'b0, 32'h0000_0000, r);
    chk(r & 32'h0000_0034, 32'(errM * 4 + secM * 16 + fastM * 32));
    errM = 0;
  endtask : rdSt

  task automatic cmd(input logic [3:0] c, input logic [15:0] a);
    wr(8'h04, {8'h00, a, 4'h0, c});
    repeat (3) @(posedge clk_sys);
  endtask : cmd

  task automatic fpp(input logic [3:0] c, input logic [15:0] a);
    fppCmdValid <= 1'b1;
    fppCmd <= c;
    fppArg <= a;
    @(posedge clk_sys);
    fppCmdValid <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask : fpp

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : print_verdict

  initial begin
    repeat (16) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    wr(8'h1C, 32'hFFFF_FFFF);
    rd(8'h1C, 32'h0000_0000);
    rd(8'h0C, 32'h0000_0000);
    rd(8'h10, {16'h0000, CAL, 8'h00});
    rdSt();
    $display("test reset done");
    wr(8'h00, 32'h0000_0001);
    for (int i = 0; i < 7; i++) begin
      rnd = lfsr(rnd);
      if (i == 0 || rnd[3]) begin
        cmd(flp_pkg::FLP_CMD_SET_LOCK, 16'(i * 32 + rnd[8:4]));
        lockM |= 1 << i;
      end
    end
    rd(8'h0C, 32'(lockM));
    for (int i = 0; i < 8; i++) begin
      pg = i * 32 + (i % 2) * 31;
      cmd(i % 2 ? flp_pkg::FLP_CMD_PAGE_ERASE : flp_pkg::FLP_CMD_PAGE_PROG, 16'(pg));
      if (lockM[i]) errM = 1;
      else begin
        eS++;
        chk(lastPage, pg);
      end
      chk(flashIrq_ff, errM);
      chk(nProg, eS);
      rdSt();
    end
    wr(8'h00, 32'h0000_0000);
    cmd(flp_pkg::FLP_CMD_PAGE_PROG, 16'h0005);
    errM = 1;
    chk(flashIrq_ff, 1'b0);
    cmd(flp_pkg::FLP_CMD_FULL_ERASE, 16'h0000);
    chk(nFull, eF);
    rdSt();
    for (int i = 0; i < 7; i++) if (lockM[i]) cmd(flp_pkg::FLP_CMD_CLR_LOCK, 16'(i * 32));
    lockM = 0;
    rd(8'h0C, 32'h0000_0000);
    $display("test locks done");
    for (int k = 0; k < 3; k++) begin
      cmd(k < 2 ? flp_pkg::FLP_CMD_SET_GP : flp_pkg::FLP_CMD_CLR_GP, 16'(k != 1));
      gpM = k < 2 ? gpM | (1 << (k != 1)) : gpM & 2'b01;
      chk({bodResetEnable_ff, bodEnable_ff}, gpM);
    end
    cmd(flp_pkg::FLP_CMD_SET_GP, 16'h0001);
    gpM = 3;
    rd(8'h10, {16'h0000, CAL, 8'h03});
    $display("test general bits done");
    straps <= 4'hE;
    repeat (8) @(posedge clk_sys);
    fastM = 1;
    chk(fastProgMode_ff, 1'b1);
    foreach (codes[j]) begin
      fpp(codes[j], 16'h00E0);
      if (codes[j] == 4'h1 || codes[j] == 4'h2) eS++;
      if (codes[j] == 4'h3) eF++;
    end
    gpM = 2;
    secM = 1;
    repeat (60) @(posedge clk_sys);
    chk(nDone, 9);
    chk(nProg, eS);
    chk(nFull, eF);
    rd(8'h10, {16'h0000, CAL, 8'h02});
    $display("test fast port done");
    fpp(flp_pkg::FLP_CMD_SET_LOCK, 16'h00E0);
    chk(nRef, 1);
    dbgAccessReq <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk(dbgAccessGrant_ff, 1'b0);
    straps <= 4'h0;
    repeat (8) @(posedge clk_sys);
    fastM = 0;
    cmd(flp_pkg::FLP_CMD_FULL_ERASE, 16'h0000);
    repeat (60) @(posedge clk_sys);
    rdSt();
    cmd(flp_pkg::FLP_CMD_SET_LOCK, 16'h0060);
    rd(8'h0C, 32'h0000_0008);
    wipePin <= 1'b1;
    repeat (WIPE_CYC) @(posedge clk_sys);
    chk({bodResetEnable_ff, bodEnable_ff}, 2'b00);
    wipePin <= 1'b0;
    repeat (8) @(posedge clk_sys);
    wr(8'h10, 32'hFFFF_FFFF);
    rd(8'h0C, 32'h0000_0000);
    rd(8'h10, {16'h0000, CAL, 8'h00});
    slow <= 1'b1;
    cmd(flp_pkg::FLP_CMD_FULL_ERASE, 16'h0000);
    repeat (60) @(posedge clk_sys);
    secM = 0;
    rdSt();
    chk(dbgAccessGrant_ff, 1'b1);
    chk(nFull, eF + 2);
    $display("test security done");
    straps <= 4'hF;
    repeat (RST_CYC + 20) @(posedge clk_sys);
    chk(nBoot, 1);
    straps <= 4'h0;
    $display("test boot restore done");
    print_verdict();
  end
endmodule : flp_nvm_protect_tb
